// ==== rtl/modbus_slave_pkg.sv ====
// Purpose: Constants, register map and types for the serial request slave.
// Assumes: 40 MHz pclk, 11-bit characters on the line.
// Notes:   Timing counts are derived from times in their own units.
// Behaviour
// - Five bit rates, 8 data bits, parity/stop options
// - Slave number from constant or port register
// - Gap of 1.5 characters at 9600, 750 us at faster rates, is inter-character timeout
// - Gap of 3.5 characters at 9600, 1.75 ms at faster rates, marks frame boundary
// - Timeout mid-reception discards all received data
// - Execute held request only at end of scan
// - Broadcast writes executed, broadcast reads not; broadcasts never answered
// - Frame address is low five digits minus one
// - Outputs, relays, special relays, inputs: decimal times eight plus octal digit
// - Coil ranges at 1, 701, 1001, 9001
// - Input relay ranges, function 2 only
// - Input register ranges, function 4 only
// - Data registers 400001 and 408001, functions 3/6/16
// - Preset value ranges accept function 3 only
// - Slave number zero is broadcast write
// - Frame fields, error reply sets bit 7
package modbus_slave_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int     CLK_HZ        = 40_000_000;
	localparam int     CLK_PERIOD_NS = 25;
	localparam int     BAUD_RATE [5] = '{9600, 19200, 38400, 57600, 115200};
	localparam int     BAUD_SEL_MAX  = 4;
	localparam longint T15_FAST_NS   = 750_000;
	localparam longint T35_FAST_NS   = 1_750_000;
	localparam longint T15_HALF_BITS = 33;
	localparam longint T35_HALF_BITS = 77;
	localparam int T15_FAST_CYC = int'((T15_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int T35_FAST_CYC = int'((T35_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int T15_SLOW_CYC = int'((longint'(CLK_HZ) * T15_HALF_BITS + 2 * BAUD_RATE[0] - 1)
		/ (2 * BAUD_RATE[0]));
	localparam int T35_SLOW_CYC = int'((longint'(CLK_HZ) * T35_HALF_BITS + 2 * BAUD_RATE[0] - 1)
		/ (2 * BAUD_RATE[0]));

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFS        = 8'h00;
	localparam logic [7:0]  SLAVE_CONST_OFS = 8'h04;
	localparam logic [7:0]  PORT2_SLAVE_OFS = 8'h08;
	localparam logic [7:0]  PORT3_SLAVE_OFS = 8'h0c;
	localparam logic [7:0]  STATUS_OFS      = 8'h10;
	localparam int          CTRL_BAUD_LSB   = 0;
	localparam int          CTRL_PAR_LSB    = 3;
	localparam int          CTRL_STOP2_BIT  = 5;
	localparam int          CTRL_SRC_BIT    = 6;
	localparam int          CTRL_PORT_BIT   = 7;
	localparam logic [2:0]  BAUD_RST        = 3'h0;
	localparam logic [1:0]  PAR_NONE        = 2'h0;
	localparam logic [1:0]  PAR_ODD         = 2'h1;
	localparam logic [1:0]  PAR_EVEN        = 2'h2;
	localparam logic [7:0]  SLAVE_MIN       = 8'h01;
	localparam logic [7:0]  SLAVE_MAX       = 8'hf7;
	localparam logic [7:0]  SLAVE_CONST_RST = 8'h01;
	localparam logic [7:0]  BROADCAST_ID    = 8'h00;

	// ---------------------------------------------------------------
	// Frame layout and codes
	// ---------------------------------------------------------------
	localparam int          FRAME_DEPTH  = 256;
	localparam logic [8:0]  FRAME_MIN    = 9'h004;
	localparam logic [15:0] CRC_INIT     = 16'hffff;
	localparam logic [15:0] CRC_POLY     = 16'ha001;
	localparam logic [7:0]  FC_ERR_BIT   = 8'h80;
	localparam logic [7:0]  FC_RD_COILS  = 8'h01;
	localparam logic [7:0]  FC_RD_INPUTS = 8'h02;
	localparam logic [7:0]  FC_RD_HOLD   = 8'h03;
	localparam logic [7:0]  FC_RD_INREG  = 8'h04;
	localparam logic [7:0]  FC_WR_COIL   = 8'h05;
	localparam logic [7:0]  FC_WR_REG    = 8'h06;
	localparam logic [7:0]  FC_WR_COILS  = 8'h0f;
	localparam logic [7:0]  FC_WR_REGS   = 8'h10;
	localparam logic [7:0]  EXC_NONE     = 8'h00;
	localparam logic [7:0]  EXC_FUNC     = 8'h01;
	localparam logic [7:0]  EXC_ADDR     = 8'h02;
	localparam logic [7:0]  EXC_VALUE    = 8'h03;
	localparam logic [15:0] MAX_BITS     = 16'h0080;
	localparam logic [15:0] MAX_WORDS    = 16'h0040;

	// ---------------------------------------------------------------
	// Address map: outputs, shift, relays, special relays, inputs,
	// timer/counter contacts, current values, data, special data,
	// timer/counter presets
	// ---------------------------------------------------------------
	localparam int RANGE_N = 13;
	localparam int ADDR_DIGITS_MOD = 100000;
	localparam int RANGE_MB_OFS [RANGE_N] = '{1, 701, 1001, 9001, 100001, 101001, 101501,
		300001, 300501, 400001, 408001, 409001, 409501};
	localparam int RANGE_SIZE [RANGE_N] = '{112, 128, 1024, 144, 126, 200, 200, 200, 200,
		2000, 200, 200, 200};
	localparam int RANGE_MIN [RANGE_N] = '{0, 0, 0, 8000, 0, 0, 0, 0, 0, 0, 8000, 0, 0};
	localparam logic [1:0] SP_COIL = 2'h0;
	localparam logic [1:0] SP_INPUT = 2'h1;
	localparam logic [1:0] SP_INREG = 2'h2;
	localparam logic [1:0] SP_HOLD = 2'h3;
	localparam logic [1:0] RANGE_SPACE [RANGE_N] = '{SP_COIL, SP_COIL, SP_COIL, SP_COIL,
		SP_INPUT, SP_INPUT, SP_INPUT, SP_INREG, SP_INREG, SP_HOLD, SP_HOLD, SP_HOLD, SP_HOLD};
	localparam logic RANGE_OCTAL [RANGE_N] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
		1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	localparam logic RANGE_RD_ONLY [RANGE_N] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
		1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	localparam int OCTAL_RADIX = 8;
	localparam int DECIMAL_RADIX = 10;

	typedef enum logic [5:0] {
		ST_SYNC  = 6'b000001,
		ST_READY = 6'b000010,
		ST_RECV  = 6'b000100,
		ST_GAP   = 6'b001000,
		ST_CHECK = 6'b010000,
		ST_PEND  = 6'b100000
	} frame_state_e;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA  = 5'b00100,
		RX_PAR   = 5'b01000,
		RX_STOP  = 5'b10000
	} char_state_e;

	function automatic logic [15:0] frame_addr(input int mb);
		return 16'((mb % ADDR_DIGITS_MOD) - 1);
	endfunction

endpackage

// ==== rtl/uart_char_rx.sv ====
// Purpose: Receive one asynchronous character, 8 data bits.
// Assumes: rx_line already synchronised to pclk.
// Notes:   Mid-bit sampling; parity and stop faults flagged.
`timescale 1ns/1ps
module uart_char_rx
	import modbus_slave_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        rx_line,
	input  wire logic [15:0] bit_div,
	input  wire logic [1:0]  parity_mode,
	input  wire logic        two_stop,
	output logic             byte_valid,
	output logic [7:0]       byte_data,
	output logic             byte_err,
	output logic             busy
);

	char_state_e st;
	logic [15:0] cnt;
	logic [2:0]  nbit;
	logic        par;
	logic        bad;
	logic        stops_left;

	assign busy = (st != RX_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st         <= RX_IDLE;
			cnt        <= 16'h0000;
			nbit       <= 3'h0;
			par        <= 1'b0;
			bad        <= 1'b0;
			stops_left <= 1'b0;
			byte_data  <= 8'h00;
			byte_valid <= 1'b0;
			byte_err   <= 1'b0;
		end else if (ce) begin
			byte_valid <= 1'b0;
			if (st != RX_IDLE && cnt != 16'h0000) begin
				cnt <= cnt - 16'h0001;
			end else begin
				unique case (st)
					RX_IDLE: if (!rx_line) begin
						st  <= RX_START;
						cnt <= {1'b0, bit_div[15:1]};
					end
					RX_START: begin
						// Glitch shorter than half a bit is not a start
						st   <= rx_line ? RX_IDLE : RX_DATA;
						cnt  <= bit_div - 16'h0001;
						nbit <= 3'h0;
						par  <= 1'b0;
						bad  <= 1'b0;
					end
					RX_DATA: begin
						byte_data  <= {rx_line, byte_data[7:1]};
						par        <= par ^ rx_line;
						nbit       <= nbit + 3'h1;
						cnt        <= bit_div - 16'h0001;
						stops_left <= two_stop;
						if (nbit == 3'h7) begin
							st <= (parity_mode == PAR_NONE) ? RX_STOP : RX_PAR;
						end
					end
					RX_PAR: begin
						bad <= ((par ^ rx_line) != (parity_mode == PAR_ODD));
						cnt <= bit_div - 16'h0001;
						st  <= RX_STOP;
					end
					RX_STOP: begin
						cnt <= bit_div - 16'h0001;
						if (stops_left) begin
							stops_left <= 1'b0;
							bad        <= bad | !rx_line;
						end else begin
							st         <= RX_IDLE;
							byte_valid <= 1'b1;
							byte_err   <= bad | !rx_line;
						end
					end
					default: st <= RX_IDLE;
				endcase
			end
		end
	end

endmodule // uart_char_rx

// ==== rtl/modbus_rtu_slave.sv ====
// Purpose: Serial request slave front end with device address map.
// Assumes: end_of_scan and frame_rd_idx come from pclk logic.
// Notes:   Access and reply are handed out as decoded commands.
`timescale 1ns/1ps
module modbus_rtu_slave
	import modbus_slave_pkg::*;
#(
	parameter int T15_FAST_CYCLES = T15_FAST_CYC,
	parameter int T35_FAST_CYCLES = T35_FAST_CYC,
	parameter int T15_SLOW_CYCLES = T15_SLOW_CYC,
	parameter int T35_SLOW_CYCLES = T35_SLOW_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	input  wire logic        end_of_scan,
	input  wire logic [7:0]  frame_rd_idx,
	output logic [7:0]       frame_rd_data,
	output logic             access_go,
	output logic             access_write,
	output logic             access_bcast,
	output logic [3:0]       access_class,
	output logic [15:0]      access_index,
	output logic [15:0]      access_dev_num,
	output logic [15:0]      access_count,
	output logic             reply_go,
	output logic [7:0]       reply_fc,
	output logic [7:0]       reply_exc
);

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	logic [2:0]  baud_sel;
	logic [1:0]  parity_mode;
	logic        two_stop;
	logic        slave_src;
	logic        port_sel;
	logic [7:0]  slave_const;
	logic [15:0] port2_slave_number_reg;
	logic [15:0] port3_slave_number_reg;
	logic [7:0]  good_count;
	logic [7:0]  drop_count;
	logic        addr_hit;
	logic [31:0] rd_mux;
	logic        wr_en;
	frame_state_e st;

	assign wr_en = psel && penable && pready && pwrite;

	always_comb begin
		addr_hit = 1'b1;
		rd_mux   = 32'h0000_0000;
		case (paddr)
			CTRL_OFS: rd_mux = {24'h000000, port_sel, slave_src, two_stop, parity_mode, baud_sel};
			SLAVE_CONST_OFS: rd_mux = {24'h000000, slave_const};
			PORT2_SLAVE_OFS: rd_mux = {16'h0000, port2_slave_number_reg};
			PORT3_SLAVE_OFS: rd_mux = {16'h0000, port3_slave_number_reg};
			STATUS_OFS: rd_mux = {8'h00, drop_count, good_count, 2'b00, st};
			default: addr_hit = 1'b0;
		endcase
	end

	// Read data settles in the setup cycle so pready can be a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			if (psel && !penable && !pready) begin
				pready  <= 1'b1;
				pslverr <= !addr_hit;
				prdata  <= rd_mux;
			end else begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_sel               <= BAUD_RST;
			parity_mode            <= PAR_NONE;
			two_stop               <= 1'b0;
			slave_src              <= 1'b0;
			port_sel               <= 1'b0;
			slave_const            <= SLAVE_CONST_RST;
			port2_slave_number_reg <= 16'h0000;
			port3_slave_number_reg <= 16'h0000;
		end else if (ce && wr_en) begin
			case (paddr)
				CTRL_OFS: begin
					if (pwdata[CTRL_BAUD_LSB +: 3] <= 3'(BAUD_SEL_MAX)) begin
						baud_sel <= pwdata[CTRL_BAUD_LSB +: 3];
					end
					if (pwdata[CTRL_PAR_LSB +: 2] != 2'h3) begin
						parity_mode <= pwdata[CTRL_PAR_LSB +: 2];
					end
					two_stop  <= pwdata[CTRL_STOP2_BIT];
					slave_src <= pwdata[CTRL_SRC_BIT];
					port_sel  <= pwdata[CTRL_PORT_BIT];
				end
				SLAVE_CONST_OFS: begin
					if (pwdata[7:0] >= SLAVE_MIN && pwdata[7:0] <= SLAVE_MAX) begin
						slave_const <= pwdata[7:0];
					end
				end
				PORT2_SLAVE_OFS: port2_slave_number_reg <= pwdata[15:0];
				PORT3_SLAVE_OFS: port3_slave_number_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Line input and character receiver
	// ---------------------------------------------------------------
	logic        rx_meta;
	logic        rx_sync;
	logic        byte_valid;
	logic [7:0]  byte_data;
	logic        byte_err;
	logic        rx_busy;
	logic [15:0] bit_div;

	assign bit_div = 16'(CLK_HZ / BAUD_RATE[baud_sel]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else if (ce) begin
			rx_meta <= rxd;
			rx_sync <= rx_meta;
		end
	end

	uart_char_rx u_char_rx (
		.pclk        (pclk),
		.presetn     (presetn),
		.ce          (ce),
		.rx_line     (rx_sync),
		.bit_div     (bit_div),
		.parity_mode (parity_mode),
		.two_stop    (two_stop),
		.byte_valid  (byte_valid),
		.byte_data   (byte_data),
		.byte_err    (byte_err),
		.busy        (rx_busy)
	);

	// ---------------------------------------------------------------
	// Idle gap timing
	// ---------------------------------------------------------------
	logic [17:0] gap_cnt;
	logic        gap15;
	logic        gap35;

	// Fixed times above 9600 bit/s, where character-based gaps get too short
	assign gap15 = gap_cnt >= ((baud_sel == BAUD_RST) ? 18'(T15_SLOW_CYCLES)
		: 18'(T15_FAST_CYCLES));
	assign gap35 = gap_cnt >= ((baud_sel == BAUD_RST) ? 18'(T35_SLOW_CYCLES)
		: 18'(T35_FAST_CYCLES));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_cnt <= 18'h00000;
		end else if (ce) begin
			if (rx_busy || byte_valid) begin
				gap_cnt <= 18'h00000;
			end else if (!gap35) begin
				gap_cnt <= gap_cnt + 18'h00001;
			end
		end
	end

	// ---------------------------------------------------------------
	// Frame capture and CRC
	// ---------------------------------------------------------------
	logic [7:0]  frame_buf [FRAME_DEPTH];
	logic [8:0]  frame_len;
	logic [15:0] crc;
	logic [7:0]  own_id;
	logic        addressed;
	logic        store;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	assign own_id = slave_src ? (port_sel ? port3_slave_number_reg[7:0]
		: port2_slave_number_reg[7:0]) : slave_const;
	assign addressed = (frame_buf[0] == own_id) || (frame_buf[0] == BROADCAST_ID);
	assign store = byte_valid && !byte_err && (st == ST_READY || st == ST_RECV);

	always_ff @(posedge pclk) begin
		if (ce && store && !frame_len[8]) begin
			frame_buf[frame_len[7:0]] <= byte_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_rd_data <= 8'h00;
		end else if (ce) begin
			frame_rd_data <= frame_buf[frame_rd_idx];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_len <= 9'h000;
			crc       <= CRC_INIT;
		end else if (ce) begin
			if (st == ST_READY && !store) begin
				frame_len <= 9'h000;
				crc       <= CRC_INIT;
			end else if (store && !frame_len[8]) begin
				frame_len <= frame_len + 9'h001;
				crc       <= crc_step(crc, byte_data);
			end
		end
	end

	// ---------------------------------------------------------------
	// Request decode and address map
	// ---------------------------------------------------------------
	logic [7:0]  fc;
	logic [15:0] req_addr;
	logic [15:0] req_qty;
	logic [1:0]  space;
	logic        space_ok;
	logic        bit_fc;
	logic        dec_write;
	logic [7:0]  dec_exc;
	logic [3:0]  dec_class;
	logic [15:0] dec_index;
	logic [15:0] dec_num;
	logic [15:0] dec_count;
	logic [16:0] last_addr;
	logic [15:0] base;
	logic        hit;

	assign fc       = frame_buf[1];
	assign req_addr = {frame_buf[2], frame_buf[3]};
	assign req_qty  = {frame_buf[4], frame_buf[5]};

	always_comb begin
		space     = SP_COIL;
		space_ok  = 1'b1;
		bit_fc    = 1'b0;
		dec_write = 1'b0;
		dec_count = req_qty;
		case (fc)
			FC_RD_COILS: bit_fc = 1'b1;
			FC_WR_COIL: begin
				bit_fc    = 1'b1;
				dec_write = 1'b1;
				dec_count = 16'h0001;
			end
			FC_WR_COILS: begin
				bit_fc    = 1'b1;
				dec_write = 1'b1;
			end
			FC_RD_INPUTS: begin
				space  = SP_INPUT;
				bit_fc = 1'b1;
			end
			FC_RD_INREG: space = SP_INREG;
			FC_RD_HOLD: space = SP_HOLD;
			FC_WR_REG: begin
				space     = SP_HOLD;
				dec_write = 1'b1;
				dec_count = 16'h0001;
			end
			FC_WR_REGS: begin
				space     = SP_HOLD;
				dec_write = 1'b1;
			end
			default: space_ok = 1'b0;
		endcase
	end

	always_comb begin
		dec_exc   = EXC_NONE;
		dec_class = 4'h0;
		dec_index = 16'h0000;
		dec_num   = 16'h0000;
		hit       = 1'b0;
		base      = 16'h0000;
		last_addr = {1'b0, req_addr} + {1'b0, dec_count} - 17'h00001;
		if (!space_ok) begin
			dec_exc = EXC_FUNC;
		end else if (dec_count == 16'h0000 || dec_count > (bit_fc ? MAX_BITS : MAX_WORDS)) begin
			dec_exc = EXC_VALUE;
		end else begin
			for (int i = 0; i < RANGE_N; i++) begin
				base = frame_addr(RANGE_MB_OFS[i]);
				if (!hit && RANGE_SPACE[i] == space && req_addr >= base
					&& last_addr < 17'(base) + 17'(RANGE_SIZE[i])) begin
					hit       = 1'b1;
					dec_class = 4'(i);
					dec_index = req_addr - base;
					if (RANGE_OCTAL[i]) begin
						dec_num = 16'(RANGE_MIN[i] + int'(dec_index) / OCTAL_RADIX
							* DECIMAL_RADIX + int'(dec_index[2:0]));
					end else begin
						dec_num = 16'(RANGE_MIN[i] + int'(dec_index));
					end
					if (RANGE_RD_ONLY[i] && fc != FC_RD_HOLD) begin
						dec_exc = EXC_FUNC;
					end
				end
			end
			if (!hit) begin
				dec_exc = EXC_ADDR;
			end
		end
	end

	// ---------------------------------------------------------------
	// Frame sequencer
	// ---------------------------------------------------------------
	logic frame_ok;

	assign frame_ok = (frame_len >= FRAME_MIN) && !frame_len[8] && (crc == 16'h0000)
		&& addressed;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_SYNC;
		end else if (ce) begin
			unique case (st)
				ST_SYNC: if (gap35) st <= ST_READY;
				ST_READY: if (store) st <= ST_RECV;
				ST_RECV: begin
					if (byte_valid && byte_err) begin
						st <= ST_SYNC;
					end else if (gap15) begin
						st <= ST_GAP;
					end
				end
				ST_GAP: begin
					// A character after 1.5 but before 3.5 breaks the frame
					if (rx_busy || byte_valid) begin
						st <= ST_SYNC;
					end else if (gap35) begin
						st <= ST_CHECK;
					end
				end
				ST_CHECK: st <= frame_ok ? ST_PEND : ST_READY;
				ST_PEND: if (end_of_scan) st <= ST_READY;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			good_count <= 8'h00;
			drop_count <= 8'h00;
		end else if (ce && st == ST_CHECK) begin
			if (frame_ok) begin
				good_count <= good_count + 8'h01;
			end else begin
				drop_count <= drop_count + 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// Held request, released at end of scan
	// ---------------------------------------------------------------
	logic       held_bcast;
	logic [7:0] held_exc;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_write   <= 1'b0;
			access_bcast   <= 1'b0;
			access_class   <= 4'h0;
			access_index   <= 16'h0000;
			access_dev_num <= 16'h0000;
			access_count   <= 16'h0000;
			reply_fc       <= 8'h00;
			held_bcast     <= 1'b0;
			held_exc       <= EXC_NONE;
		end else if (ce && st == ST_CHECK && frame_ok) begin
			access_write   <= dec_write;
			access_bcast   <= (frame_buf[0] == BROADCAST_ID);
			access_class   <= dec_class;
			access_index   <= dec_index;
			access_dev_num <= dec_num;
			access_count   <= dec_count;
			reply_fc       <= (dec_exc != EXC_NONE) ? (fc | FC_ERR_BIT) : fc;
			held_bcast     <= (frame_buf[0] == BROADCAST_ID);
			held_exc       <= dec_exc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_go <= 1'b0;
			reply_go  <= 1'b0;
			reply_exc <= EXC_NONE;
		end else if (ce) begin
			access_go <= 1'b0;
			reply_go  <= 1'b0;
			if (st == ST_PEND && end_of_scan) begin
				// Broadcast only ever writes; a broadcast read has nobody to answer
				access_go <= (held_exc == EXC_NONE) && (!held_bcast || access_write);
				reply_go  <= !held_bcast;
				reply_exc <= held_exc;
			end
		end
	end

endmodule // modbus_rtu_slave

// ==== test/modbus_rtu_slave_properties.sv ====
// Purpose: Port checks of the request slave.
// Assumes: One clock, async low reset.
// Notes:   Bound into the slave.
`timescale 1ns/1ps
module modbus_rtu_slave_chk (
	input wire logic        pclk, presetn, ce, psel, penable, pready, end_of_scan,
	input wire logic        access_go, access_write, access_bcast, reply_go,
	input wire logic [3:0]  access_class,
	input wire logic [15:0] access_index, access_dev_num,
	input wire logic [7:0]  reply_fc, reply_exc
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_apb_zero_wait: assert property (psel && !penable && ce |=> pready)
		else $error("pready late");
	a_go_after_scan: assert property ((access_go || reply_go) |-> $past(end_of_scan))
		else $error("action without end of scan");
	a_go_one_pulse: assert property (access_go |=> !access_go)
		else $error("access_go too long");
	a_bcast_silent: assert property (access_go && access_bcast |-> !reply_go)
		else $error("broadcast answered");
	a_exc_fc_bit: assert property (reply_go && reply_exc != 8'h00 |-> reply_fc[7])
		else $error("error reply without bit 7");
	a_exc_no_access: assert property (reply_go && reply_exc != 8'h00 |-> !access_go)
		else $error("access despite error reply");
	a_read_only_space: assert property (access_go && access_write |->
		!(access_class inside {[4'h4:4'h8], 4'hb, 4'hc}))
		else $error("write to read-only space");
	a_octal_dev: assert property (access_go && access_class == 4'h2 |->
		access_dev_num == (access_index >> 3) * 16'h000a + access_index[2:0])
		else $error("octal device number wrong");
	a_word_dev: assert property (access_go && access_class == 4'h9 |->
		access_dev_num == access_index)
		else $error("word device number wrong");
endmodule // modbus_rtu_slave_chk

bind modbus_rtu_slave modbus_rtu_slave_chk i_modbus_rtu_slave_chk (.pclk, .presetn, .ce,
	.psel, .penable, .pready, .end_of_scan, .access_go, .access_write, .access_bcast,
	.reply_go, .access_class, .access_index, .access_dev_num, .reply_fc, .reply_exc);

// ==== test/modbus_master_model.sv ====
// Purpose: Serial request master on the receive line.
// Assumes: 8 data bits, no parity, one stop bit.
// Notes:   Appends the CRC; line idles high.
`timescale 1ns/1ps
module modbus_master_model
	import modbus_slave_pkg::*;
#(
	parameter int DIV = 347
) (
	input wire logic pclk,
	output logic     rxd
);
	initial rxd = 1'b1;
	task automatic put_bit(input logic v);
		rxd <= v;
		repeat (DIV) @(posedge pclk);
	endtask
	task automatic send(input logic [7:0] b [6]);
		logic [7:0]  f [8];
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 6; i++) begin
			f[i] = b[i];
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		f[6] = c[7:0];
		f[7] = c[15:8];
		// Bytes back to back, no gap inside a frame
		for (int i = 0; i < 8; i++) begin
			put_bit(1'b0);
			for (int k = 0; k < 8; k++)
				put_bit(f[i][k]);
			put_bit(1'b1);
		end
	endtask
endmodule // modbus_master_model

// ==== test/modbus_rtu_slave_tb_top.sv ====
// Purpose: Register, frame and end-of-scan tests of the slave.
// Assumes: 115200 baud, shortened gap counts.
// Notes:   Each frame is released by one end-of-scan pulse.
`timescale 1ns/1ps
module modbus_rtu_slave_tb_top
	import modbus_slave_pkg::*;
;
	localparam int T35 = 3000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, end_of_scan;
	logic        access_go, access_write, access_bcast, reply_go, e;
	logic [7:0]  paddr, frame_rd_idx, frame_rd_data, reply_fc, reply_exc;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  access_class;
	logic [15:0] access_index, access_dev_num, access_count;
	logic [71:0] seen;
	int          n_errors, tests_run, cyc;
	assign seen = {access_go, access_write, access_bcast, access_class, access_index,
		access_dev_num, access_count, reply_go, reply_fc, reply_exc};
	always #12.5 pclk = ~pclk;
	modbus_rtu_slave #(.T15_FAST_CYCLES(1200), .T35_FAST_CYCLES(T35)) i_modbus_rtu_slave (
		.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rxd, .end_of_scan, .frame_rd_idx, .frame_rd_data, .access_go,
		.access_write, .access_bcast, .access_class, .access_index, .access_dev_num,
		.access_count, .reply_go, .reply_fc, .reply_exc);
	modbus_master_model #(.DIV(CLK_HZ / BAUD_RATE[BAUD_SEL_MAX])) i_modbus_master_model (
		.pclk, .rxd);
	task automatic chk(input string nm, input logic [79:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic req(input logic [7:0] b [6]);
		i_modbus_master_model.send(b);
		repeat (T35 + 20) @(posedge pclk);
		chk("held", {access_go, reply_go}, 80'h0);
		end_of_scan <= 1'b1;
		@(posedge pclk);
		end_of_scan <= 1'b0;
		@(posedge pclk);
	endtask
	always @(posedge pclk) begin
		cyc++;
		// Three frames of about 30800 cycles each plus register setup
		if (cyc == 99000) begin
			n_errors++;
			conclude();
		end
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, end_of_scan, paddr, pwdata} = 44'h0;
		frame_rd_idx = 8'h01;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl", q, 80'h0);
		apb(1'b1, SLAVE_CONST_OFS, 32'h0000_00f8);
		apb(1'b0, SLAVE_CONST_OFS, 32'h0);
		chk("slave const", q, SLAVE_CONST_RST);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", e, 1'b1);
		apb(1'b1, PORT2_SLAVE_OFS, 32'h0000_0005);
		apb(1'b1, CTRL_OFS, 32'h0000_0044);
		repeat (T35) @(posedge pclk);
		req('{8'h05, FC_RD_HOLD, 8'h02, 8'hf4, 8'h00, 8'h02});
		chk("fc byte", frame_rd_data, FC_RD_HOLD);
		chk("hold read", seen, {3'b100, 4'h9, 16'h02f4, 16'h02f4, 16'h0002, 1'b1,
			FC_RD_HOLD, EXC_NONE});
		req('{BROADCAST_ID, FC_WR_COIL, 8'h04, 8'hed, 8'hff, 8'h00});
		chk("bcast coil", seen, {3'b111, 4'h2, 16'h0105, 16'h0145, 16'h0001, 1'b0,
			FC_WR_COIL, EXC_NONE});
		req('{8'h05, FC_WR_REG, 8'h23, 8'h28, 8'h00, 8'h01});
		chk("preset write", {access_go, reply_go, reply_fc, reply_exc},
			{2'b01, FC_ERR_BIT | FC_WR_REG, EXC_FUNC});
		// Three good frames counted, none dropped, back in the ready state
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("status", q, 32'h0000_0302);
		conclude();
	end
endmodule // modbus_rtu_slave_tb_top
